// ---- rtl/admod_pkg.sv ----
// shared constants and types of the result data modification stage
`default_nettype none
package admod_pkg;
  // sizes
  localparam int NumResults = 16;
  localparam int ConvWidth  = 12;
  localparam int ValWidth   = 16;
  localparam int FiltWidth  = 14;
  localparam int AddrWidth  = 8;
  localparam int DataWidth  = 32;

  // modification modes
  localparam logic [1:0] ModeReduce = 2'h0;
  localparam logic [1:0] ModeFilter = 2'h1;
  localparam logic [1:0] ModeDiff   = 2'h2;

  // control codes
  localparam logic [3:0] ReduceOff     = 4'h0;
  localparam logic [3:0] ReduceMaxCode = 4'h3;
  localparam logic [3:0] FirLastCode   = 4'hd;
  localparam logic [3:0] IirCodeLow    = 4'he;

  // special result registers
  localparam logic [3:0] BaseReg     = 4'h0;
  localparam logic [3:0] FiltRegLow  = 4'h7;
  localparam logic [3:0] FiltRegHigh = 4'hf;

  // register map: region codes of paddr[7:6], byte addresses of status and mask
  localparam logic [1:0] RegionCtrl   = 2'h0;
  localparam logic [1:0] RegionResult = 2'h1;
  localparam logic [7:0] StatusOffset = 8'h80;
  localparam logic [7:0] MaskOffset   = 8'h84;

  // field positions
  localparam int CtrlRedLsb    = 0;
  localparam int CtrlModeLsb   = 4;
  localparam int ResCounterLsb = 16;
  localparam int ResPrimedBit  = 20;
  localparam int ResValidBit   = 31;

  // filter history steps before output is meaningful
  localparam logic [1:0] PrimeSteps = 2'h2;

  // fir coefficients {a,b,c}, two bits each, codes 0x0..0xd
  localparam logic [5:0] FirTable [0:13] = '{
    6'h24, 6'h18, 6'h21, 6'h15, 6'h12, 6'h34, 6'h28,
    6'h1c, 6'h31, 6'h25, 6'h19, 6'h22, 6'h16, 6'h13};
  // iir input weight for codes 0xe and 0xf
  localparam logic [1:0] IirWeightE = 2'h2;
  localparam logic [1:0] IirWeightF = 2'h3;
  localparam logic [FiltWidth-1:0] FiltMax = 14'h3fff;

  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] redCtrl;
  } admod_ctrl_t;

  typedef struct packed {
    logic [3:0]           target;
    logic [ConvWidth-1:0] data;
  } admod_conv_t;

  localparam admod_ctrl_t CtrlReset = '{mode: ModeReduce, redCtrl: ReduceOff};
endpackage
`default_nettype wire

// ---- rtl/admod_filter.sv ----
// fir and iir arithmetic with history for one filtered result register
`default_nettype none
module admod_filter (
  input  wire logic                             clock,
  input  wire logic                             rst_n,
  input  wire logic                             step,
  input  wire logic                             clear,
  input  wire logic [3:0]                       code,
  input  wire logic [admod_pkg::ConvWidth-1:0]  sample,
  output logic      [admod_pkg::FiltWidth-1:0]  filtOut
);
  import admod_pkg::*;

  logic [ConvWidth-1:0] prev1;
  logic [ConvWidth-1:0] prev2;
  logic [FiltWidth-1:0] yPrev;
  logic [5:0]           coeff;
  logic [1:0]           weight;
  logic [ValWidth-1:0]  firSum;
  logic [ValWidth+1:0]  iirSum;

  // fir: a*new + b*prev + c*prev2, gain 3 or 4, no scaling
  always_comb begin
    coeff  = (code <= FirLastCode) ? FirTable[code] : 6'h00;
    // operands widened first so no product is cut to twelve bits
    firSum = ValWidth'(coeff[5:4]) * ValWidth'(sample) + ValWidth'(coeff[3:2]) * ValWidth'(prev1)
           + ValWidth'(coeff[1:0]) * ValWidth'(prev2);
  end

  // iir: y = a*x + y - a*y/4, dc gain 4 for both weights
  always_comb begin
    weight = (code == IirCodeLow) ? IirWeightE : IirWeightF;
    iirSum = (ValWidth+2)'(weight) * (ValWidth+2)'(sample) + (ValWidth+2)'(yPrev)
           - (((ValWidth+2)'(weight) * (ValWidth+2)'(yPrev)) >> 2);
  end

  // rounding can creep past 14 bits, so clamp
  always_comb begin
    if (code <= FirLastCode) begin
      filtOut = firSum[FiltWidth-1:0];
    end else if (iirSum > (ValWidth+2)'(FiltMax)) begin
      filtOut = FiltMax;
    end else begin
      filtOut = iirSum[FiltWidth-1:0];
    end
  end

  // history shifts on each filtered conversion; a new setting restarts it
  always_ff @(posedge clock) begin
    if (!rst_n || clear) begin
      prev1 <= '0;
      prev2 <= '0;
      yPrev <= '0;
    end else if (step) begin
      prev1 <= sample;
      prev2 <= prev1;
      yPrev <= filtOut;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/admod_irq.sv ----
// sticky event status, mask and level interrupt
`default_nettype none
module admod_irq (
  input  wire logic                              clock,
  input  wire logic                              rst_n,
  input  wire logic [admod_pkg::NumResults-1:0]  events,
  input  wire logic                              statusWrite,
  input  wire logic                              maskWrite,
  input  wire logic [admod_pkg::NumResults-1:0]  wdata,
  output logic      [admod_pkg::NumResults-1:0]  status,
  output logic      [admod_pkg::NumResults-1:0]  mask,
  output logic                                   irq
);
  import admod_pkg::*;

  // write one to clear; an event in the same cycle wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~(statusWrite ? wdata : '0)) | events;
    end
  end

  // mask of the same layout, one enables the bit
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mask <= '0;
    end else if (maskWrite) begin
      mask <= wdata;
    end
  end

  assign irq = |(status & mask);
endmodule
`default_nettype wire

// ---- rtl/admod_core.sv ----
// result data modification stage: sixteen result registers behind apb
//
// Implementation choices: the address map and the APB slave port.
`default_nettype none
module admod_core (
  input  wire logic                              clock,
  input  wire logic                              rst_n,
  // conversion results from the converter core
  input  wire logic                              convValid,
  input  wire admod_pkg::admod_conv_t            conv,
  // apb slave
  input  wire logic [admod_pkg::AddrWidth-1:0]   paddr,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [admod_pkg::DataWidth-1:0]   pwdata,
  output logic      [admod_pkg::DataWidth-1:0]   prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // completion events
  output logic      [admod_pkg::NumResults-1:0]  resultEvent,
  output logic                                   irq
);
  import admod_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic                 setupPhase;
  logic                 accessDone;
  logic                 busWrite;
  logic                 busRead;
  logic [1:0]           region;
  logic [3:0]           regIndex;
  logic                 aligned;
  logic                 isStatus;
  logic                 isMask;
  logic                 mapped;
  logic                 ackPending;
  logic                 errPending;
  logic [DataWidth-1:0] readWord;

  assign setupPhase = psel & ~penable;
  assign region     = paddr[7:6];
  assign regIndex   = paddr[5:2];
  assign aligned    = (paddr[1:0] == 2'h0);
  assign isStatus   = (paddr == StatusOffset);
  assign isMask     = (paddr == MaskOffset);
  assign mapped     = isStatus | isMask
                    | (aligned & ((region == RegionCtrl) | (region == RegionResult)));

  // answer one cycle after setup, so read data comes from a flip-flop
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ackPending <= 1'b0;
      errPending <= 1'b0;
    end else begin
      ackPending <= setupPhase;
      errPending <= setupPhase & ~mapped;
    end
  end

  assign pready     = psel & penable & ackPending;
  assign pslverr    = pready & errPending;
  assign accessDone = pready & ~errPending;
  assign busWrite   = accessDone & pwrite;
  assign busRead    = accessDone & ~pwrite;

  ////////////////////////////////////////////////////////////////////////
  // per result register state

  admod_ctrl_t          ctrl      [NumResults];
  logic [ValWidth-1:0]  value     [NumResults];
  logic [1:0]           counter   [NumResults];
  logic [1:0]           primed    [NumResults];
  logic [FiltWidth-1:0] filtOut   [NumResults];
  logic [NumResults-1:0] valid;
  logic [NumResults-1:0] doneEvent;
  logic [ValWidth-1:0]  convWide;

  // twelve-bit sample widened once for the accumulate and difference adders
  assign convWide = ValWidth'(conv.data);

  genvar gi;
  generate
    for (gi = 0; gi < NumResults; gi++) begin : g_res
      localparam logic [3:0] Idx = 4'(gi);
      localparam bit CanFilter = (Idx == FiltRegLow) || (Idx == FiltRegHigh);
      localparam bit CanDiff   = (Idx != BaseReg);

      logic [1:0] effMode;
      logic       hit;
      logic       ctrlWrite;
      logic       resultRead;
      logic       reduceOn;
      logic       seqStart;
      logic       done;

      assign hit        = convValid & (conv.target == Idx);
      assign ctrlWrite  = busWrite & (region == RegionCtrl) & (regIndex == Idx) & aligned;
      assign resultRead = busRead & (region == RegionResult) & (regIndex == Idx) & aligned;

      // modes a register cannot carry fall back to plain storage
      always_comb begin
        if (ctrl[gi].mode == ModeFilter && CanFilter) begin
          effMode = ModeFilter;
        end else if (ctrl[gi].mode == ModeDiff && CanDiff) begin
          effMode = ModeDiff;
        end else begin
          effMode = ModeReduce;
        end
      end

      // codes above 0x3, and modes the register cannot carry, mean reduction off
      assign reduceOn = (ctrl[gi].mode == ModeReduce) && (ctrl[gi].redCtrl != ReduceOff)
                     && (ctrl[gi].redCtrl <= ReduceMaxCode);
      assign seqStart = reduceOn && (counter[gi] == 2'h0);

      // a sequence is complete only when the counter lands on zero
      always_comb begin
        if (!hit) begin
          done = 1'b0;
        end else if (reduceOn) begin
          done = !seqStart && (counter[gi] == 2'h1);
        end else begin
          done = 1'b1;
        end
      end
      assign doneEvent[gi] = done;

      // control register, written by software
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          ctrl[gi] <= CtrlReset;
        end else if (ctrlWrite) begin
          ctrl[gi].mode  <= pwdata[CtrlModeLsb +: 2];
          ctrl[gi].redCtrl <= pwdata[CtrlRedLsb +: 4];
        end
      end

      // result value per mode
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          value[gi] <= '0;
        end else if (hit) begin
          case (effMode)
            ModeFilter: begin
              value[gi] <= ValWidth'(filtOut[gi]);
            end
            ModeDiff: begin
              value[gi] <= convWide - value[0];
            end
            default: begin
              if (reduceOn && !seqStart) begin
                value[gi] <= value[gi] + convWide;
              end else begin
                value[gi] <= convWide;
              end
            end
          endcase
        end
      end

      // reduction counter: loaded with the code, counts down per sample
      always_ff @(posedge clock) begin
        if (!rst_n || ctrlWrite) begin
          counter[gi] <= 2'h0;
        end else if (hit) begin
          if (seqStart) begin
            counter[gi] <= ctrl[gi].redCtrl[1:0];
          end else if (reduceOn) begin
            counter[gi] <= counter[gi] - 2'h1;
          end else begin
            counter[gi] <= 2'h0;
          end
        end
      end

      // valid: set on completion wins; a late read while the next
      // sequence runs leaves it set
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          valid[gi] <= 1'b0;
        end else if (done) begin
          valid[gi] <= 1'b1;
        end else if (resultRead && counter[gi] == 2'h0) begin
          valid[gi] <= 1'b0;
        end
      end

      if (CanFilter) begin : g_filt
        logic filtStep;

        assign filtStep = hit & (effMode == ModeFilter);

        admod_filter u_filter (
          .clock   (clock),
          .rst_n   (rst_n),
          .step    (filtStep),
          .clear   (ctrlWrite),
          .code    (ctrl[gi].redCtrl),
          .sample  (conv.data),
          .filtOut (filtOut[gi])
        );

        // warm-up count, so software can see the history is full
        always_ff @(posedge clock) begin
          if (!rst_n || ctrlWrite) begin
            primed[gi] <= 2'h0;
          end else if (filtStep && primed[gi] != PrimeSteps) begin
            primed[gi] <= primed[gi] + 2'h1;
          end
        end
      end else begin : g_nofilt
        assign filtOut[gi] = '0;
        assign primed[gi]  = PrimeSteps;
      end
    end
  endgenerate

  assign resultEvent = doneEvent;

  ////////////////////////////////////////////////////////////////////////
  // events and interrupt

  logic [NumResults-1:0] status;
  logic [NumResults-1:0] mask;
  logic                  statusWrite;
  logic                  maskWrite;

  assign statusWrite = busWrite & isStatus;
  assign maskWrite   = busWrite & isMask;

  admod_irq u_irq (
    .clock       (clock),
    .rst_n       (rst_n),
    .events      (doneEvent),
    .statusWrite (statusWrite),
    .maskWrite   (maskWrite),
    .wdata       (pwdata[NumResults-1:0]),
    .status      (status),
    .mask        (mask),
    .irq         (irq)
  );

  ////////////////////////////////////////////////////////////////////////
  // read path

  // read word assembled from the address seen in the setup cycle
  always_comb begin
    readWord = '0;
    if (isStatus) begin
      readWord[NumResults-1:0] = status;
    end else if (isMask) begin
      readWord[NumResults-1:0] = mask;
    end else if (aligned && region == RegionCtrl) begin
      readWord[CtrlModeLsb +: 2]  = ctrl[regIndex].mode;
      readWord[CtrlRedLsb +: 4]   = ctrl[regIndex].redCtrl;
    end else if (aligned && region == RegionResult) begin
      readWord[ValWidth-1:0]        = value[regIndex];
      readWord[ResCounterLsb +: 2]  = counter[regIndex];
      readWord[ResPrimedBit]        = (primed[regIndex] == PrimeSteps);
      readWord[ResValidBit]         = valid[regIndex];
    end
  end

  // captured in setup, so a write or event one cycle later is not mixed in
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (setupPhase) begin
      prdata <= (mapped && !pwrite) ? readWord : '0;
    end
  end
endmodule
`default_nettype wire

// ---- sim/admod_core_properties.sv ----
// port-level properties of the result data modification stage
`default_nettype none
module admod_core_properties
  import admod_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire logic                  convValid,
  input wire admod_pkg::admod_conv_t conv,
  input wire logic [AddrWidth-1:0]  paddr,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [DataWidth-1:0]  prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [NumResults-1:0] resultEvent,
  input wire logic                  irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // register bus: zero wait states, refusal only inside the access cycle
  ready_in_access_a: assert property (psel && !penable ##1 psel && penable |-> pready)
    else $error("pready missing in access cycle");
  ready_only_access_a: assert property (!(psel && penable) |-> !pready && !pslverr)
    else $error("pready or pslverr outside access");
  refuse_unmapped_a: assert property (psel && penable && (paddr[1:0] != 2'h0 || paddr > MaskOffset) |-> pslverr)
    else $error("unmapped access not refused");
  write_reads_zero_a: assert property (psel && penable && pwrite |-> prdata == '0)
    else $error("write returned read data");
  // read data may only move at the edge that ends a setup cycle
  read_data_steady_a: assert property (!$past(psel && !penable) |-> $stable(prdata))
    else $error("read data moved during access");

  ////////////////////////////////////////////////////////////////////////////////
  // completion events only with a sample, only for its own register
  event_needs_conv_a: assert property (resultEvent != '0 |-> convValid)
    else $error("result event without conversion");
  event_own_target_a: assert property (convValid |-> (resultEvent & ~(16'h1 << conv.target)) == '0)
    else $error("result event on wrong register");
  // irq can only rise from a completion or unmasking, fall from clearing or masking
  irq_rise_cause_a: assert property ($rose(irq) |-> $past(resultEvent != '0)
    || $past(psel && penable && pwrite && paddr == MaskOffset))
    else $error("irq rose without cause");
  irq_fall_cause_a: assert property ($fell(irq) |->
    $past(psel && penable && pwrite && (paddr == StatusOffset || paddr == MaskOffset)))
    else $error("irq fell without cause");
endmodule

bind admod_core admod_core_properties u_props (
  .clock(clock), .rst_n(rst_n), .convValid(convValid), .conv(conv), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .resultEvent(resultEvent), .irq(irq));
`default_nettype wire

// ---- sim/admod_conv_model.sv ----
// converter core model: feeds queued conversion results, one per cycle
`default_nettype none
module admod_conv_model (
  input  wire logic              clock,
  input  wire logic              rst_n,
  output logic                   convValid,
  output admod_pkg::admod_conv_t conv
);
  timeunit 1ns;
  timeprecision 1ps;
  import admod_pkg::*;
  admod_conv_t q [$];

  initial begin
    convValid = 1'b0;
    conv      = '0;
  end

  // back to back while work is queued; idle bus toggles so stale data never looks valid
  always @(posedge clock) begin
    if (rst_n && q.size() != 0) begin
      convValid <= 1'b1;
      conv      <= q.pop_front();
    end else begin
      convValid <= 1'b0;
      conv      <= ~conv;
    end
  end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench of the result data modification stage
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import admod_pkg::*;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, irq, convValid;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] resultEvent;
  logic        e;
  admod_conv_t conv;
  logic [31:0] seed = 32'h00011ad8;
  int md[16], cd[16], vl[16], ct[16], vld[16], h1[16], h2[16], sp[16];
  int stat, msk, ev, n_mismatch, checks, cyc;
  int fir[14] = '{210, 120, 201, 111, 102, 310, 220, 130, 301, 211, 121, 202, 112, 103};

  admod_conv_model u_conv (.clock(clock), .rst_n(rst_n), .convValid(convValid), .conv(conv));
  admod_core u_dut (.clock(clock), .rst_n(rst_n), .convValid(convValid), .conv(conv), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .resultEvent(resultEvent), .irq(irq));

  always #2 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard, far above the fewer than one thousand cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reference model of the result registers
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed[11:0]);
  endfunction

  function automatic int effm(int t);
    if ((md[t] == 1 && t != 7 && t != 15) || (md[t] == 2 && t == 0) || md[t] == 3) return 0;
    return md[t];
  endfunction

  function automatic logic [31:0] rd(int t);
    logic [31:0] r;
    r = 32'(vl[t]) | (32'(ct[t]) << 16);
    // warm-up is only tracked on the two filter-capable registers
    r[20] = (t == 7 || t == 15) ? (sp[t] >= 2) : 1'b1;
    r[31] = vld[t][0];
    return r;
  endfunction

  task automatic step(int t, int d, output int done);
    int m, c, a;
    m = effm(t);
    c = (m == md[t]) ? cd[t] : 0;
    done = 1;
    if (m == 1 && c <= 13) begin
      vl[t] = fir[c] / 100 * d + fir[c] / 10 % 10 * h1[t] + fir[c] % 10 * h2[t];
      h2[t] = h1[t];
      h1[t] = d;
    end else if (m == 1) begin
      a = (c == 14) ? 2 : 3;
      h1[t] = a * d + h1[t] - a * h1[t] / 4;
      if (h1[t] > 16383) h1[t] = 16383;
      vl[t] = h1[t];
    end else if (m == 2) begin
      vl[t] = (d - vl[0]) & 65535;
    end else if (ct[t] == 0) begin
      vl[t] = d;
      ct[t] = (c <= 3) ? c : 0;
      done = (ct[t] == 0);
    end else begin
      vl[t] += d;
      ct[t]--;
      done = (ct[t] == 0);
    end
    if (m == 1) sp[t]++;
    if (done) begin
      vld[t] = 1;
      stat |= 1 << t;
    end
  endtask

  // every accepted sample updates the model and checks its completion pulse
  always @(negedge clock) begin
    if (rst_n && convValid) begin
      step(int'(conv.target), int'(conv.data), ev);
      check({16'h0, resultEvent}, 32'(ev << conv.target));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus and stream tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    // answer taken at the rising edge where pready is seen, then released
    do @(posedge clock); while (pready !== 1'b1);
    r   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d, q, e);
    check({31'h0, e}, 32'h0);
    if (a < 8'h40) begin
      md[a / 4] = int'(d[5:4]);
      cd[a / 4] = int'(d[3:0]);
      ct[a / 4] = 0;
      h1[a / 4] = 0;
      h2[a / 4] = 0;
      sp[a / 4] = 0;
    end
    if (a == StatusOffset) stat &= ~d;
    if (a == MaskOffset) msk = int'(d[15:0]);
  endtask

  task automatic rdreg(logic [7:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0, q, e);
    check(q, exp);
  endtask

  task automatic rdres(int t);
    rdreg(8'(64 + 4 * t), rd(t));
    if (ct[t] == 0) vld[t] = 0;
  endtask

  task automatic setc(int t, logic [1:0] m, logic [3:0] c);
    wr(8'(4 * t), {26'h0, m, c});
  endtask

  task automatic send(int t);
    u_conv.q.push_back('{target: 4'(t), data: 12'(rnd())});
  endtask

  task automatic flush();
    while (u_conv.q.size() != 0) @(posedge clock);
    repeat (2) @(posedge clock);
  endtask

  task automatic irqchk();
    @(negedge clock);
    check({31'h0, irq}, 32'((stat & msk) != 0));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clock   = 1'b0;
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h0;
    pwdata  = 32'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    for (int t = 0; t < 16; t++) begin
      rdreg(8'(4 * t), 32'h0);
      rdres(t);
    end
    rdreg(StatusOffset, 32'h0);
    rdreg(MaskOffset, 32'h0);
    apb(1'b0, 8'h88, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    apb(1'b1, 8'h42, 32'hffff, q, e);
    check({31'h0, e}, 32'h1);
    wr(MaskOffset, 32'hffff);
    // every register in reduce mode, codes 0..3, interleaved back to back
    for (int t = 0; t < 16; t++) setc(t, ModeReduce, 4'(t % 4));
    for (int k = 0; k < 64; k++) send(k % 16);
    flush();
    for (int t = 0; t < 16; t++) rdres(t);
    for (int t = 0; t < 16; t++) rdres(t);
    rdreg(StatusOffset, 32'(stat));
    irqchk();
    wr(StatusOffset, 32'hffff);
    irqchk();
    wr(MaskOffset, 32'h0);
    send(1);
    send(1);
    flush();
    irqchk();
    wr(MaskOffset, 32'h2);
    irqchk();
    // every filter code on both filter registers, refused on an ordinary one
    for (int c = 0; c < 16; c++) begin
      setc(7, ModeFilter, 4'(c));
      setc(15, ModeFilter, 4'(15 - c));
      setc(3, ModeFilter, 4'(c));
      for (int k = 0; k < 12; k++) send((k % 3 == 0) ? 7 : (k % 3 == 1) ? 15 : 3);
      flush();
      rdres(7);
      rdres(15);
      rdres(3);
    end
    // difference against register 0, refused on register 0 itself
    setc(0, ModeReduce, 4'h0);
    setc(5, ModeDiff, 4'h0);
    send(0);
    send(5);
    send(5);
    send(0);
    send(5);
    flush();
    rdres(5);
    setc(0, ModeDiff, 4'h0);
    setc(11, 2'h3, 4'h0);
    send(0);
    send(11);
    flush();
    rdres(0);
    rdres(11);
    print_verdict();
  end
endmodule
`default_nettype wire
